// file: hdl/sfx_pkg.sv
// Purpose: Shared constants and carrier types for the shared flag byte exchange coordinator
// Assumes: Fixed rack of four CPUs, one 256-byte shared flag area
// Notes: Group enables come from jumpers, one bit per 32-byte group
//==================================================================
// Package
//==================================================================
package sfx_pkg;
   // Rack size
   localparam int NUM_CPU = 4;
   localparam int CPU_W = 2;
   // Shared flag area layout
   localparam int FLAG_BYTES = 256;
   localparam int ADDR_W = 8;
   localparam int GROUP_BYTES = 32;
   localparam int NUM_GROUPS = 8;
   localparam int GROUP_POS = 5;
   localparam int GROUP_W = 3;
   // Longest uninterrupted group, in bytes and in sixteen-bit words
   localparam logic [6:0] BLOCK_MAX_BYTES = 7'h40;
   localparam int BLOCK_MAX_WORDS = 32;
   // Reset values
   localparam logic [NUM_GROUPS-1:0] GROUP_EN_RST = 8'h00;
   localparam logic [CPU_W-1:0] OWNER_RST = 2'h0;
   localparam logic [6:0] HOLD_CNT_RST = 7'h00;

   // Arbiter states, one-hot
   typedef enum logic [2:0]
   {
      SFX_IDLE = 3'b001,
      SFX_GRANT = 3'b010,
      SFX_HOLD = 3'b100
   } sfx_state_t;

   // One byte request from a CPU
   typedef struct packed
   {
      logic valid;
      logic write;
      logic shared;
      logic extended;
      logic group_hold;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } sfx_req_t;

   // Answer to the CPU that was just served
   typedef struct packed
   {
      logic done;
      logic refused;
      logic [CPU_W-1:0] cpu;
      logic [7:0] data;
   } sfx_rsp_t;
endpackage : sfx_pkg

// file: hdl/sfx_coordinator.sv
// Purpose: Coordinator that grants the backplane to CPUs in turn and stores shared flag bytes
// Assumes: CPUs hold a request steady until the clock edge at which they see it granted
// Notes: One byte per grant unless the requester asks to hold the group semaphore
//
// Functional notes
// - Bytes not marked shared are refused and never exchanged.
// - Extended flag area bytes are refused for exchange.
// - 256 shared byte locations, enabled in eight groups of 32.
// - A masked group is not answered; its bytes are refused here.
// - CPUs exchange their shared bytes at each program cycle end.
// - Grant rotates through CPUs; only the grant holder transfers.
// - Normal mode moves one byte per grant, interleaving CPUs.
// - Without group mode multi-byte values may arrive across rounds.
// - Group option holds a semaphore so the whole group goes uninterrupted.
// - Other CPUs wait, flagged as delayed, while the semaphore is held.
// - One uninterrupted group is capped at 64 bytes.
// - Coordinator stores shared bytes; producers write, consumers read.
`timescale 1ns/10ps
`default_nettype none
module sfx_coordinator
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [sfx_pkg::NUM_GROUPS-1:0] group_enable_pin,
   input wire sfx_pkg::sfx_req_t [sfx_pkg::NUM_CPU-1:0] cpu_req,
   output logic [sfx_pkg::NUM_CPU-1:0] cpu_grant,
   output logic [sfx_pkg::NUM_CPU-1:0] cpu_wait,
   output sfx_pkg::sfx_rsp_t rsp
);
   import sfx_pkg::*;

   //==================================================================
   // Declarations
   //==================================================================
   sfx_state_t state_reg;
   sfx_state_t state_next;
   logic [NUM_GROUPS-1:0] group_meta_reg;
   logic [NUM_GROUPS-1:0] group_en_reg;
   logic [CPU_W-1:0] owner_reg;
   logic [CPU_W-1:0] owner_next;
   logic [6:0] hold_cnt_reg;
   sfx_rsp_t rsp_reg;
   logic [7:0] flag_mem [0:FLAG_BYTES-1];
   logic [NUM_CPU-1:0] req_valid;
   sfx_req_t cur_req;
   logic taken;
   logic accept;
   logic keep_hold;
   logic [CPU_W:0] pick;

   // Round robin search starting after cur; the top bit says a requester was found
   function automatic logic [CPU_W:0] next_owner(input logic [NUM_CPU-1:0] reqs,
                                                  input logic [CPU_W-1:0] cur);
      logic [CPU_W:0] res;
      logic [CPU_W-1:0] idx;
      res = {1'b0, cur};
      for (int k = NUM_CPU; k >= 1; k--)
      begin
         idx = CPU_W'(cur + CPU_W'(k));
         if (reqs[idx])
         begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction : next_owner

   //==================================================================
   // Jumper synchroniser
   //==================================================================
   // Jumpers are static, but still come from a pin, so two flops first
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         group_meta_reg <= GROUP_EN_RST;
         group_en_reg <= GROUP_EN_RST;
      end
      else
      begin
         group_meta_reg <= group_enable_pin;
         group_en_reg <= group_meta_reg;
      end
   end

   //==================================================================
   // Request decode
   //==================================================================
   // Only the owner's request is decoded; the rest give just valid bits to the pick and wait their turn
   always_comb
   begin
      for (int i = 0; i < NUM_CPU; i++)
      begin
         req_valid[i] = cpu_req[i].valid;
      end
      cur_req = cpu_req[owner_reg];
      taken = (state_reg != SFX_IDLE) && cur_req.valid;
      // Local, extended or masked bytes are never exchanged
      accept = taken && cur_req.shared && !cur_req.extended
               && group_en_reg[cur_req.addr[GROUP_POS +: GROUP_W]];
      // Semaphore keeps the grant until the group or the 64-byte cap ends
      keep_hold = taken && cur_req.group_hold
                  && (hold_cnt_reg < BLOCK_MAX_BYTES - 7'h01);
      pick = next_owner(req_valid, owner_reg);
   end

   //==================================================================
   // Arbiter state
   //==================================================================
   // Grant moves to the next requester after every byte unless the semaphore is held; a lone requester keeps it
   always_comb
   begin
      state_next = state_reg;
      owner_next = owner_reg;
      case (state_reg)
         SFX_IDLE:
         begin
            if (pick[CPU_W])
            begin
               state_next = SFX_GRANT;
               owner_next = pick[CPU_W-1:0];
            end
         end
         SFX_GRANT, SFX_HOLD:
         begin
            if (keep_hold)
            begin
               state_next = SFX_HOLD;
            end
            else if (state_reg == SFX_HOLD && !taken)
            begin
               // Semaphore holder keeps the bus between its bytes, others wait
               state_next = SFX_HOLD;
            end
            else if (pick[CPU_W])
            begin
               state_next = SFX_GRANT;
               owner_next = pick[CPU_W-1:0];
            end
            else
            begin
               state_next = SFX_IDLE;
            end
         end
         default:
         begin
            state_next = SFX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_reg <= SFX_IDLE;
         owner_reg <= OWNER_RST;
      end
      else
      begin
         state_reg <= state_next;
         owner_reg <= owner_next;
      end
   end

   // Byte count inside one uninterrupted group
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         hold_cnt_reg <= HOLD_CNT_RST;
      end
      else if (keep_hold)
      begin
         hold_cnt_reg <= hold_cnt_reg + 7'h01;
      end
      else if (taken || state_reg == SFX_IDLE)
      begin
         hold_cnt_reg <= HOLD_CNT_RST;
      end
   end

   //==================================================================
   // Shared flag storage
   //==================================================================
   // Memory has no reset; contents are undefined until a producer writes
   always_ff @(posedge clock)
   begin
      if (accept && cur_req.write)
      begin
         flag_mem[cur_req.addr] <= cur_req.data;
      end
   end

   // Answer one cycle after the byte is taken
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rsp_reg <= '0;
      end
      else
      begin
         rsp_reg.done <= taken;
         rsp_reg.refused <= taken && !accept;
         rsp_reg.cpu <= owner_reg;
         rsp_reg.data <= (accept && !cur_req.write) ? flag_mem[cur_req.addr] : 8'h00;
      end
   end

   //==================================================================
   // Outputs
   //==================================================================
   // Grant is decoded from the owner flop; wait shows requesting CPUs that do not hold the grant
   always_comb
   begin
      for (int i = 0; i < NUM_CPU; i++)
      begin
         cpu_grant[i] = (state_reg != SFX_IDLE) && (owner_reg == CPU_W'(i));
         cpu_wait[i] = cpu_req[i].valid && !cpu_grant[i];
      end
   end
   assign rsp = rsp_reg;

   //==================================================================
   // Assertions
   //==================================================================
   sequence seq_take;
      taken;
   endsequence

   sequence seq_answer;
      rsp.done && (rsp.cpu == $past(owner_reg));
   endsequence

   grant_onehot_a: assert property (@(posedge clock) disable iff (sys_rst)
      $onehot0(cpu_grant))
      else $error("more than one grant");

   answer_follows_a: assert property (@(posedge clock) disable iff (sys_rst)
      seq_take |=> seq_answer)
      else $error("taken byte not answered next cycle");

   masked_refused_a: assert property (@(posedge clock) disable iff (sys_rst)
      taken && cur_req.shared && !cur_req.extended
      && !group_en_reg[cur_req.addr[GROUP_POS +: GROUP_W]] |=> rsp.refused)
      else $error("masked group answered");

   extended_refused_a: assert property (@(posedge clock) disable iff (sys_rst)
      taken && cur_req.extended |=> rsp.refused)
      else $error("extended byte exchanged");

   local_refused_a: assert property (@(posedge clock) disable iff (sys_rst)
      taken && !cur_req.shared |=> rsp.refused && (rsp.data == 8'h00))
      else $error("local byte exchanged");

   byte_advance_a: assert property (@(posedge clock) disable iff (sys_rst)
      taken && !cur_req.group_hold && ((req_valid & ~cpu_grant) != '0)
      |=> cpu_grant != $past(cpu_grant))
      else $error("grant not advanced after one byte");

   hold_keeps_a: assert property (@(posedge clock) disable iff (sys_rst)
      keep_hold |=> $stable(cpu_grant) && state_reg == SFX_HOLD)
      else $error("semaphore holder lost grant");

   // The byte taken at the last count must end the held group
   group_cap_a: assert property (@(posedge clock) disable iff (sys_rst)
      taken && (hold_cnt_reg == BLOCK_MAX_BYTES - 7'h01) |=> state_reg != SFX_HOLD)
      else $error("group exceeded 64 bytes");

   store_write_a: assert property (@(posedge clock) disable iff (sys_rst)
      accept && cur_req.write |=> flag_mem[$past(cur_req.addr)] == $past(cur_req.data))
      else $error("shared byte not stored");

   waiters_flagged_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == SFX_HOLD |-> ((cpu_wait | cpu_grant) & req_valid) == req_valid)
      else $error("waiting CPU not flagged");
endmodule : sfx_coordinator
`default_nettype wire

// file: bench/sfx_cpu_model.sv
// Purpose: Behavioural rack of CPUs requesting shared flag bytes
// Assumes: Bench queues byte requests per CPU
// Notes: A slow CPU idles gap cycles after each take
`timescale 1ns/10ps
`default_nettype none
module sfx_cpu_model
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [sfx_pkg::NUM_CPU-1:0] cpu_grant,
   input wire sfx_pkg::sfx_rsp_t rsp,
   output sfx_pkg::sfx_req_t [sfx_pkg::NUM_CPU-1:0] cpu_req
);
   import sfx_pkg::*;
   sfx_req_t q[NUM_CPU][$];
   sfx_rsp_t got[NUM_CPU][$];
   int gap = 0;
   int idle[NUM_CPU] = '{default: 0};
   initial cpu_req = '0;
   //==================================================================
   // CPU request side
   //==================================================================
   // Advance right at the take so a held group streams a byte per cycle
   always @(posedge clock)
   begin
      for (int i = 0; i < NUM_CPU; i++)
      begin
         if (!sys_rst && cpu_grant[i] && cpu_req[i].valid)
         begin
            void'(q[i].pop_front());
            idle[i] = gap;
         end
         if (!sys_rst && rsp.done && rsp.cpu == i)
            got[i].push_back(rsp);
         if (idle[i] == 0 && q[i].size() > 0)
            cpu_req[i] <= q[i][0];
         else
            cpu_req[i] <= {1'b0, ~cpu_req[i][$bits(sfx_req_t)-2:0]}; // Released lines toggle
         if (idle[i] > 0)
            idle[i]--;
      end
   end
endmodule : sfx_cpu_model
`default_nettype wire

// file: bench/tb_shared_flag_byte_exchange.sv
// Purpose: Self-checking bench for the shared flag byte coordinator
// Assumes: CPU model logs every answer per CPU
// Notes: Jumper changes wait three cycles for the synchroniser
`timescale 1ns/10ps
`default_nettype none
module tb_shared_flag_byte_exchange;
   import sfx_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [NUM_GROUPS-1:0] group_enable_pin = 8'hFF;
   sfx_req_t [NUM_CPU-1:0] cpu_req;
   logic [NUM_CPU-1:0] cpu_grant;
   logic [NUM_CPU-1:0] cpu_wait;
   sfx_rsp_t rsp;
   int err_count = 0;
   int n_compared = 0;
   int w1 = 0;
   int b;
   logic [CPU_W-1:0] seq[$];
   sfx_coordinator i_sfx_coordinator (.clock(clock), .sys_rst(sys_rst),
      .group_enable_pin(group_enable_pin), .cpu_req(cpu_req), .cpu_grant(cpu_grant),
      .cpu_wait(cpu_wait), .rsp(rsp));
   sfx_cpu_model i_sfx_cpu_model (.clock(clock), .sys_rst(sys_rst), .cpu_grant(cpu_grant),
      .rsp(rsp), .cpu_req(cpu_req));
   //==================================================================
   // Clock, log and helpers
   //==================================================================
   initial
   begin
      forever #2 clock = ~clock;
   end
   // Answer order, and CPU1 waits seen while CPU0 holds the bus
   always @(posedge clock)
   begin
      if (rsp.done === 1'b1)
         seq.push_back(rsp.cpu);
      if (cpu_wait[1] === 1'b1 && cpu_grant[0] === 1'b1)
         w1++;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Flags are write, shared, extended, hold
   task post(input int c, input logic [3:0] f, input logic [7:0] a, input logic [7:0] d);
      i_sfx_cpu_model.q[c].push_back({1'b1, f, a, d});
   endtask : post
   task settle(input int k);
      int n;
      n = 0;
      while (seq.size() < b + k && n < 500)
      begin
         @(posedge clock);
         n++;
      end
      check(8'(n < 500), 8'h01);
      repeat (2) @(posedge clock);
   endtask : settle
   task answer(input int c, input logic r, input logic [7:0] d);
      sfx_rsp_t a;
      a = i_sfx_cpu_model.got[c].pop_front();
      check({7'h00, a.refused}, {7'h00, r});
      check(a.data, d);
   endtask : answer
   //==================================================================
   // Scenarios
   //==================================================================
   // One producer per byte, another CPU consumes it; top byte of each group
   task t_store;
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
         b = seq.size();
         post(1, 4'hC, 8'(g * 32 + 31), 8'(8'hA0 + g));
         settle(1);
         b = seq.size();
         post(2, 4'h4, 8'(g * 32 + 31), 8'h00);
         settle(1);
         answer(1, 1'b0, 8'h00);
         answer(2, 1'b0, 8'(8'hA0 + g));
      end
   endtask : t_store
   // Local, extended and masked bytes are refused by a slow CPU
   task t_refuse;
      group_enable_pin <= 8'hFB;
      i_sfx_cpu_model.gap = 3;
      repeat (3) @(posedge clock);
      b = seq.size();
      post(0, 4'h8, 8'h3F, 8'h11);
      post(0, 4'hE, 8'h3F, 8'h22);
      post(0, 4'hC, 8'h5F, 8'h33);
      post(0, 4'h4, 8'h3F, 8'h00);
      settle(4);
      answer(0, 1'b1, 8'h00);
      answer(0, 1'b1, 8'h00);
      answer(0, 1'b1, 8'h00);
      answer(0, 1'b0, 8'hA1);
      group_enable_pin <= 8'hFF;
      i_sfx_cpu_model.gap = 0;
      repeat (3) @(posedge clock);
      b = seq.size();
      post(0, 4'h4, 8'h5F, 8'h00);
      settle(1);
      answer(0, 1'b0, 8'hA2);
   endtask : t_refuse
   // Four CPUs with two bytes each rotate strictly
   task t_round;
      b = seq.size();
      for (int c = 0; c < NUM_CPU; c++)
      begin
         post(c, 4'h4, 8'h1F, 8'h00);
         post(c, 4'h4, 8'h1F, 8'h00);
      end
      settle(8);
      for (int i = 1; i < 8; i++)
         check(8'(seq[b + i] != seq[b + i - 1]), 8'h01);
      for (int i = 4; i < 8; i++)
         check(8'(seq[b + i]), 8'(seq[b + i - 4]));
      for (int c = 0; c < 8; c++)
         answer(c / 2, 1'b0, 8'hA0);
   endtask : t_round
   // Held group runs uninterrupted, then the 64-byte cap
   task t_group;
      b = seq.size();
      post(3, 4'h4, 8'h1F, 8'h00);
      settle(1);
      answer(3, 1'b0, 8'hA0);
      b = seq.size();
      w1 = 0;
      post(0, 4'hD, 8'h00, 8'h5A);
      post(0, 4'hD, 8'h01, 8'h5B);
      post(0, 4'hC, 8'h02, 8'h5C);
      post(1, 4'h4, 8'h00, 8'h00);
      post(2, 4'h4, 8'h02, 8'h00);
      settle(5);
      for (int i = 0; i < 5; i++)
         check(8'(seq[b + i]), (i < 3) ? 8'h00 : 8'(i - 2));
      check(8'(w1), 8'h03);
      for (int i = 0; i < 3; i++)
         answer(0, 1'b0, 8'h00);
      answer(1, 1'b0, 8'h5A);
      answer(2, 1'b0, 8'h5C);
      b = seq.size();
      for (int i = 0; i < 66; i++)
         post(3, (i < 65) ? 4'hD : 4'hC, 8'(8'h80 + i), 8'(i + 1));
      post(1, 4'h4, 8'h80, 8'h00);
      settle(67);
      check(8'(seq[b + 63]), 8'h03);
      check(8'(seq[b + 64]), 8'h01);
      answer(1, 1'b0, 8'h01);
      for (int i = 0; i < 66; i++)
         answer(3, 1'b0, 8'h00);
   endtask : t_group
   //==================================================================
   // Run control
   //==================================================================
   task summarize;
      if (err_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial
   begin
      #40000;
      err_count++;
      summarize();
   end
   initial
   begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      check({4'h0, cpu_grant}, 8'h00);
      check({7'h00, rsp.done}, 8'h00);
      t_store();
      t_refuse();
      t_round();
      t_group();
      summarize();
   end
endmodule : tb_shared_flag_byte_exchange
`default_nettype wire
